/* File: logic/leafu_core.sv */
// Load effective address, memory request and result formatting
module leafu_core (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        srst_i,
  // Request from the sequencer
  input  wire logic                        req_valid_i,
  input  wire leafu_pkg::leafu_req_t       req_i,
  output logic                             req_ready_o,
  // Data memory
  output leafu_pkg::leafu_mem_t            mem_o,
  input  wire logic                        mem_rvalid_i,
  input  wire logic [leafu_pkg::DLEN-1:0]  mem_rdata_i,
  // Writebacks
  output leafu_pkg::leafu_wb_t             gpr_wb_o,
  output leafu_pkg::leafu_wb_t             fpr_wb_o,
  output leafu_pkg::leafu_wb_t             base_wb_o,
  // Rejected invalid form, one-cycle pulse
  output logic                             bad_form_o
);
  typedef enum logic [1:0] {
    LEAFU_IDLE,
    LEAFU_WAIT,
    LEAFU_DONE
  } leafu_state_t;

  // Whole state of the unit
  typedef struct packed {
    leafu_state_t                    st;
    leafu_pkg::leafu_kind_t          kind;
    logic                            update;
    logic [leafu_pkg::GPR_IDX_W-1:0] base_idx;
    logic [leafu_pkg::GPR_IDX_W-1:0] tgt_idx;
    logic                            ready;
    logic                            bad;
    leafu_pkg::leafu_mem_t           mem;
    leafu_pkg::leafu_wb_t            gpr;
    leafu_pkg::leafu_wb_t            fpr;
    leafu_pkg::leafu_wb_t            basewb;
  } leafu_st_t;

  leafu_st_t                s_q;   // Registered state
  leafu_st_t                s_d;   // Next state
  logic [63:0]              dp_w;  // Widened single operand

  // Sign-extend the displacement so negative offsets reach below the base
  function automatic logic [leafu_pkg::XLEN-1:0] sext_disp(
    input logic [leafu_pkg::DISP_W-1:0] d
  );
    return {{(leafu_pkg::XLEN-leafu_pkg::DISP_W){d[leafu_pkg::DISP_W-1]}}, d};
  endfunction

  // Base operand: register 0 in the base field reads as zero, not as its contents
  function automatic logic [leafu_pkg::XLEN-1:0] base_or_zero(
    input leafu_pkg::leafu_req_t r
  );
    logic [leafu_pkg::XLEN-1:0] b;  // Selected base value
    if (r.base_gpr_field == leafu_pkg::GPR_ZERO) begin
      // Field 0 means no base at all
      b = leafu_pkg::ZERO_WORD;
    end else begin
      // Any other field uses the operand the sequencer read
      b = r.base_val;
    end
    return b;
  endfunction

  // Effective address: base-or-zero plus displacement or index
  function automatic logic [leafu_pkg::XLEN-1:0] ea_calc(leafu_pkg::leafu_req_t r);
    logic [leafu_pkg::XLEN-1:0] off;  // Second addend
    if (r.indexed) begin
      // Indexed form adds the index register
      off = r.index_val;
    end else begin
      // Displacement form adds the widened immediate
      off = sext_disp(r.disp);
    end
    // Carry out of the top bit is dropped: the address wraps around
    return base_or_zero(r) + off;
  endfunction

  // Invalid update forms: base 0, or a byte load whose base is its own target
  function automatic logic is_bad_form(leafu_pkg::leafu_req_t r);
    logic base_zero;  // Base field names register 0
    logic self_base;  // Byte load would overwrite its own base
    base_zero = (r.base_gpr_field == leafu_pkg::GPR_ZERO);
    self_base = (r.kind == leafu_pkg::LEAFU_LD_BYTE) &&
                (r.base_gpr_field == r.target_reg_field);
    return r.update && (base_zero || self_base);
  endfunction

  // Memory access size for each kind of load
  function automatic logic [2:0] size_of(leafu_pkg::leafu_kind_t k);
    logic [2:0] sz;  // Encoded size
    case (k)
      leafu_pkg::LEAFU_LD_BYTE: begin
        // One byte
        sz = leafu_pkg::SIZE_BYTE;
      end
      leafu_pkg::LEAFU_LD_FP_DOUBLE: begin
        // Eight bytes, the whole double word
        sz = leafu_pkg::SIZE_DWORD;
      end
      default: begin
        // Four bytes for the single operand
        sz = leafu_pkg::SIZE_WORD;
      end
    endcase
    return sz;
  endfunction

  // Widening converter
  leafu_sp2dp u_sp2dp (
    .sp_i (mem_rdata_i[31:0]),
    .dp_o (dp_w)
  );

  // Next-state logic
  always_comb begin
    logic bad_w;
    s_d            = s_q;
    bad_w          = 1'b0;
    s_d.bad        = 1'b0;
    s_d.mem.valid  = 1'b0;
    s_d.gpr.valid  = 1'b0;
    s_d.fpr.valid  = 1'b0;
    s_d.basewb.valid = 1'b0;
    case (s_q.st)
      LEAFU_IDLE: begin
        if (req_valid_i && s_q.ready) begin
          // Invalid forms are refused rather than executed, so a stray one
          // cannot write register 0 or lose its own loaded byte
          bad_w = is_bad_form(req_i);
          if (bad_w) begin
            // Pulse the refusal; ready stays high and memory is not touched
            s_d.bad = 1'b1;
          end else begin
            // Accept: keep what the answer needs and request memory
            s_d.kind      = req_i.kind;
            s_d.update    = req_i.update;
            s_d.base_idx  = req_i.base_gpr_field;
            s_d.tgt_idx   = req_i.target_reg_field;
            s_d.mem.valid = 1'b1;
            s_d.mem.addr  = ea_calc(req_i);
            s_d.mem.size  = size_of(req_i.kind);
            // Only one load in flight: hold off the sequencer
            s_d.ready = 1'b0;
            s_d.st    = LEAFU_WAIT;
          end
        end
      end
      LEAFU_WAIT: begin
        // Hold until memory returns the data
        if (mem_rvalid_i) begin
          case (s_q.kind)
            leafu_pkg::LEAFU_LD_BYTE: begin
              // Byte goes to a general register, upper bits cleared
              s_d.gpr.valid = 1'b1;
              s_d.gpr.idx   = s_q.tgt_idx;
              s_d.gpr.data  = {{(leafu_pkg::DLEN-leafu_pkg::BYTE_W){1'b0}},
                               mem_rdata_i[leafu_pkg::BYTE_W-1:0]};
            end
            leafu_pkg::LEAFU_LD_FP_DOUBLE: begin
              // Double word passes through untouched
              s_d.fpr.valid = 1'b1;
              s_d.fpr.idx   = s_q.tgt_idx;
              s_d.fpr.data  = mem_rdata_i;
            end
            default: begin
              // Single from the low word, widened on the way in
              s_d.fpr.valid = 1'b1;
              s_d.fpr.idx   = s_q.tgt_idx;
              s_d.fpr.data  = dp_w;
            end
          endcase
          // Base write alongside the target write
          if (s_q.update) begin
            // Address was latched at acceptance, so the base operand may change
            s_d.basewb.valid = 1'b1;
            s_d.basewb.idx   = s_q.base_idx;
            s_d.basewb.data  = {{(leafu_pkg::DLEN-leafu_pkg::XLEN){1'b0}},
                                s_q.mem.addr};
          end
          s_d.st = LEAFU_DONE;
        end
      end
      LEAFU_DONE: begin
        // One idle cycle lets the sequencer see the writeback first
        s_d.ready = 1'b1;
        s_d.st    = LEAFU_IDLE;
      end
      default: begin
        s_d.st    = LEAFU_IDLE;
        s_d.ready = 1'b1;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      // Idle, ready, and no pulse pending after reset
      s_q       <= '0;
      s_q.st    <= LEAFU_IDLE;
      s_q.ready <= 1'b1;
    end else begin
      // Every field advances each cycle; pulses clear themselves
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign req_ready_o = s_q.ready;
  assign mem_o       = s_q.mem;
  assign gpr_wb_o    = s_q.gpr;
  assign fpr_wb_o    = s_q.fpr;
  assign base_wb_o   = s_q.basewb;
  assign bad_form_o  = s_q.bad;
endmodule

/* File: logic/leafu_pkg.sv */
// Shared constants and carrier types for the load address and format unit
package leafu_pkg;
  localparam int unsigned XLEN       = 32;
  localparam int unsigned DLEN       = 64;
  localparam int unsigned DISP_W     = 16;
  localparam int unsigned GPR_IDX_W  = 5;
  localparam int unsigned BYTE_W     = 8;
  localparam logic [4:0]  GPR_ZERO   = 5'h00;
  localparam logic [XLEN-1:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [DLEN-1:0] ZERO_DWORD = 64'h0000_0000_0000_0000;
  localparam logic [2:0]  SIZE_BYTE  = 3'h1;
  localparam logic [2:0]  SIZE_WORD  = 3'h4;
  localparam logic [2:0]  SIZE_DWORD = 3'h0;
  // Single and double float field layout
  localparam int unsigned SP_EXP_W   = 8;
  localparam int unsigned SP_FRAC_W  = 23;
  localparam int unsigned DP_EXP_W   = 11;
  localparam int unsigned DP_FRAC_W  = 52;
  localparam logic [7:0]  SP_EXP_MAX = 8'hFF;
  localparam logic [7:0]  SP_EXP_MIN = 8'h00;
  localparam logic [10:0] DP_EXP_MAX = 11'h7FF;
  localparam logic [10:0] EXP_BIAS_ADJ = 11'h380;

  // Kind of load
  typedef enum logic [1:0] {
    LEAFU_LD_BYTE,
    LEAFU_LD_FP_DOUBLE,
    LEAFU_LD_FP_SINGLE
  } leafu_kind_t;

  // Decoded load request from the sequencer
  typedef struct packed {
    leafu_kind_t            kind;
    logic                   indexed;
    logic                   update;
    logic [GPR_IDX_W-1:0]   base_gpr_field;
    logic [GPR_IDX_W-1:0]   target_reg_field;
    logic [DISP_W-1:0]      disp;
    logic [XLEN-1:0]        base_val;
    logic [XLEN-1:0]        index_val;
  } leafu_req_t;

  // Memory read request
  typedef struct packed {
    logic                   valid;
    logic [XLEN-1:0]        addr;
    logic [2:0]             size;
  } leafu_mem_t;

  // Register writeback
  typedef struct packed {
    logic                   valid;
    logic [GPR_IDX_W-1:0]   idx;
    logic [DLEN-1:0]        data;
  } leafu_wb_t;
endpackage

/* File: logic/leafu_sp2dp.sv */
// Combinational single to double precision widening
module leafu_sp2dp (
  // Operand in
  input  wire logic [31:0] sp_i,
  // Widened operand out
  output logic      [63:0] dp_o
);
  always_comb begin
    // Locals at top of the process
    logic [7:0]  e;
    logic [22:0] f;
    logic [22:0] fn;
    logic [10:0] de;
    logic [4:0]  lz;
    logic        found;
    e     = sp_i[30:23];
    f     = sp_i[22:0];
    fn    = '0;
    lz    = '0;
    found = 1'b0;
    de    = '0;
    dp_o  = leafu_pkg::ZERO_DWORD;
    if (e == leafu_pkg::SP_EXP_MAX) begin
      // Infinity and NaN keep their payload
      dp_o = {sp_i[31], leafu_pkg::DP_EXP_MAX, f, 29'h00000000};
    end else if (e != leafu_pkg::SP_EXP_MIN) begin
      // Normal: rebias exponent
      de   = {3'h0, e} + leafu_pkg::EXP_BIAS_ADJ;
      dp_o = {sp_i[31], de, f, 29'h00000000};
    end else if (f == '0) begin
      // Signed zero
      dp_o = {sp_i[31], 63'h0};
    end else begin
      // Denormal single becomes normal double; find leading one
      for (int i = 22; i >= 0; i--) begin
        if (!found && f[i]) begin
          found = 1'b1;
          lz    = 5'(22 - i);
        end
      end
      fn   = 23'(f << (lz + 5'h01));
      de   = leafu_pkg::EXP_BIAS_ADJ + 11'h001 - {6'h00, lz} - 11'h001;
      dp_o = {sp_i[31], de, fn, 29'h00000000};
    end
  end
endmodule

/* File: test/leafu_core_bench.sv */
// Self-checking bench for the load address and format unit
module leafu_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
  logic                  clk_i = 1'b0;
  logic                  srst_i = 1'b1;
  logic                  req_valid_i = 1'b0;
  leafu_pkg::leafu_req_t req_i = '0;
  logic                  req_ready_o, mem_rvalid_i, bad_form_o;
  leafu_pkg::leafu_mem_t mem_o;
  leafu_pkg::leafu_wb_t  gpr_wb_o, fpr_wb_o, base_wb_o;
  logic [63:0]           mem_rdata_i;
  logic [63:0]           rd = 64'h0;
  logic [1:0]            dly = 2'h0;
  logic [71:0]           q[$];
  int                    fails = 0, num_checks = 0, seed = 74413, sp_cls = 0;
  always #25 clk_i = ~clk_i;
  leafu_core DUT (.clk_i(clk_i), .srst_i(srst_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .mem_o(mem_o), .mem_rvalid_i(mem_rvalid_i),
    .mem_rdata_i(mem_rdata_i), .gpr_wb_o(gpr_wb_o), .fpr_wb_o(fpr_wb_o),
    .base_wb_o(base_wb_o), .bad_form_o(bad_form_o));
  leafu_mem_model u_mem (.clk_i(clk_i), .mem_i(mem_o), .data_i(rd), .dly_i(dly),
    .rvalid_o(mem_rvalid_i), .rdata_o(mem_rdata_i));
  task automatic end_sim;
    if (fails == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Compare one result with the oldest note
  task automatic see(input logic [71:0] g);
    logic [71:0] e;
    e = q.size() ? q.pop_front() : '1;
    `CHK("result", e, g)
  endtask
  // Note the expected results, then hand the request over once ready
  task automatic issue(input leafu_pkg::leafu_req_t r);
    logic [31:0] ea;
    logic [2:0]  sz;
    logic [63:0] wd;
    int          n;
    @(negedge clk_i);
    rd = {$random(seed), $random(seed)};
    dly = 2'($random(seed));
    case (sp_cls)
      1: rd[30:0] = 31'h0000_0000;
      2: rd[30:23] = 8'hFF;
      3: rd[30:0] = 31'h0000_0001;
      default: rd[29] = ~rd[30];
    endcase
    ea = (r.base_gpr_field == 5'h00 ? 32'h0 : r.base_val) +
         (r.indexed ? r.index_val : {{16{r.disp[15]}}, r.disp});
    sz = r.kind == leafu_pkg::LEAFU_LD_BYTE ? leafu_pkg::SIZE_BYTE :
         r.kind == leafu_pkg::LEAFU_LD_FP_DOUBLE ? leafu_pkg::SIZE_DWORD : leafu_pkg::SIZE_WORD;
    wd = r.kind == leafu_pkg::LEAFU_LD_BYTE ? {56'h0, rd[7:0]} :
         r.kind == leafu_pkg::LEAFU_LD_FP_DOUBLE ? rd :
         {rd[31], rd[30], {3{~rd[30]}}, rd[29:0], 29'h0};
    if (r.kind == leafu_pkg::LEAFU_LD_FP_SINGLE) begin
      case (sp_cls)
        1: wd = {rd[31], 63'h0};
        2: wd = {rd[31], 11'h7FF, rd[22:0], 29'h0};
        3: wd = {rd[31], 11'h36A, 52'h0};
        default: ;
      endcase
    end
    if (r.update && (r.base_gpr_field == 5'h00 || (r.kind == leafu_pkg::LEAFU_LD_BYTE &&
        r.base_gpr_field == r.target_reg_field))) begin
      q.push_back({3'h4, 69'h0});
    end else begin
      q.push_back({3'h3, 5'h00, 29'h0, sz, ea});
      q.push_back({2'h0, r.kind != leafu_pkg::LEAFU_LD_BYTE, r.target_reg_field, wd});
      if (r.update) q.push_back({3'h2, r.base_gpr_field, 32'h0, ea});
    end
    for (n = 0; n < 40 && req_ready_o !== 1'b1; n++) @(negedge clk_i);
    if (n < 40) begin
      req_i = r;
      req_valid_i = 1'b1;
      @(negedge clk_i);
      req_valid_i = 1'b0;
    end else begin
      fails++;
      end_sim;
    end
  endtask
  // Every result the design shows is matched against the notes
  always @(negedge clk_i) begin
    if (mem_o.valid) see({3'h3, 5'h00, 29'h0, mem_o.size, mem_o.addr});
    if (gpr_wb_o.valid) see({3'h0, gpr_wb_o.idx, gpr_wb_o.data});
    if (fpr_wb_o.valid) see({3'h1, fpr_wb_o.idx, fpr_wb_o.data});
    if (base_wb_o.valid) see({3'h2, base_wb_o.idx, base_wb_o.data});
    if (bad_form_o) see({3'h4, 69'h0});
  end
  // All kinds, both address forms, with and without update, base zero in the upper half
  initial begin
    leafu_pkg::leafu_req_t r;
    repeat (2) @(negedge clk_i);
    srst_i = 1'b0;
    for (int i = 0; i < 24; i++) begin
      r = leafu_pkg::leafu_req_t'(94'({$random(seed), $random(seed), $random(seed)}));
      r.kind = leafu_pkg::leafu_kind_t'(i % 3);
      r.indexed = 1'((i / 3) % 2);
      r.update = 1'((i / 6) % 2);
      r.base_gpr_field = i >= 12 ? 5'h00 : {r.base_gpr_field[4:1], 1'b1};
      if (i == 9) r.target_reg_field = r.base_gpr_field;
      if (i == 0) r.disp = 16'h8000;
      sp_cls = i == 5 ? 3 : i == 14 ? 1 : i == 17 ? 2 : 0;
      issue(r);
    end
    repeat (8) @(negedge clk_i);
    `CHK("pending", 0, q.size())
    end_sim;
  end
endmodule

/* File: test/leafu_core_properties.sv */
// Port checks for the load address and format unit
module leafu_core_properties (
  // Clock and reset
  input wire logic                  clk_i,
  input wire logic                  srst_i,
  // Request side
  input wire logic                  req_valid_i,
  input wire leafu_pkg::leafu_req_t req_i,
  input wire logic                  req_ready_o,
  // Memory and results
  input wire leafu_pkg::leafu_mem_t mem_o,
  input wire logic                  mem_rvalid_i,
  input wire logic [63:0]           mem_rdata_i,
  input wire leafu_pkg::leafu_wb_t  gpr_wb_o,
  input wire leafu_pkg::leafu_wb_t  fpr_wb_o,
  input wire leafu_pkg::leafu_wb_t  base_wb_o,
  input wire logic                  bad_form_o
);
  logic [31:0]            ea;
  logic [31:0]            ea_q;
  logic                   tk;
  logic                   bd;
  logic                   up_q;
  leafu_pkg::leafu_kind_t kd_q;
  assign tk = req_valid_i && req_ready_o;
  // Invalid update forms must never reach memory
  assign bd = req_i.update && (req_i.base_gpr_field == 5'h00 ||
              (req_i.kind == leafu_pkg::LEAFU_LD_BYTE &&
               req_i.base_gpr_field == req_i.target_reg_field));
  assign ea = (req_i.base_gpr_field == 5'h00 ? 32'h0 : req_i.base_val) +
              (req_i.indexed ? req_i.index_val : {{16{req_i.disp[15]}}, req_i.disp});
  // Keep the taken load so its answer can be judged later
  always_ff @(posedge clk_i) begin
    if (tk) begin
      kd_q <= req_i.kind;
      up_q <= req_i.update;
      ea_q <= ea;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_take; tk && !bd; endsequence
  sequence s_done; (gpr_wb_o.valid || fpr_wb_o.valid) ##1 req_ready_o; endsequence
  property p_ea_disp; s_take ##0 !req_i.indexed |=> mem_o.valid && mem_o.addr == $past(ea);
  endproperty
  a_ea_disp: assert property (p_ea_disp) else $error("bad displacement address");
  property p_ea_idx; s_take ##0 req_i.indexed |=> mem_o.valid && mem_o.addr == $past(ea);
  endproperty
  a_ea_idx: assert property (p_ea_idx) else $error("bad indexed address");
  property p_bad; tk && bd |=> bad_form_o && !mem_o.valid; endproperty
  a_bad: assert property (p_bad) else $error("invalid form not refused");
  property p_byte; mem_rvalid_i && kd_q == leafu_pkg::LEAFU_LD_BYTE |=>
    gpr_wb_o.valid && gpr_wb_o.data == ($past(mem_rdata_i) & 64'hFF); endproperty
  a_byte: assert property (p_byte) else $error("byte result wrong");
  property p_dbl; mem_rvalid_i && kd_q == leafu_pkg::LEAFU_LD_FP_DOUBLE |=>
    fpr_wb_o.valid && fpr_wb_o.data == $past(mem_rdata_i); endproperty
  a_dbl: assert property (p_dbl) else $error("double result altered");
  property p_sgl; s_take ##0 req_i.kind == leafu_pkg::LEAFU_LD_FP_SINGLE |=>
    mem_o.size == leafu_pkg::SIZE_WORD; endproperty
  a_sgl: assert property (p_sgl) else $error("single fetch size wrong");
  property p_upd; mem_rvalid_i && up_q |=> base_wb_o.valid && base_wb_o.data == {32'h0, ea_q};
  endproperty
  a_upd: assert property (p_upd) else $error("base writeback wrong");
  property p_done; mem_rvalid_i |=> s_done; endproperty
  a_done: assert property (p_done) else $error("load result missing");
endmodule
bind leafu_core leafu_core_properties u_props (.clk_i(clk_i), .srst_i(srst_i),
  .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o), .mem_o(mem_o),
  .mem_rvalid_i(mem_rvalid_i), .mem_rdata_i(mem_rdata_i), .gpr_wb_o(gpr_wb_o),
  .fpr_wb_o(fpr_wb_o), .base_wb_o(base_wb_o), .bad_form_o(bad_form_o));

/* File: test/leafu_mem_model.sv */
// Data memory stand-in answering each read after a chosen delay
module leafu_mem_model (
  // Clock and read request
  input  wire logic                  clk_i,
  input  wire leafu_pkg::leafu_mem_t mem_i,
  // Answer content and delay
  input  wire logic [63:0]           data_i,
  input  wire logic [1:0]            dly_i,
  output logic                       rvalid_o,
  output logic [63:0]                rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rvalid_o = 1'b0;
  initial rdata_o = 64'h0;
  // Data is inverted after the answer so stale data is never trusted
  // Content is latched with the request, since the bench may already set up the next one
  always @(posedge clk_i) begin
    logic [63:0] held;
    held = data_i;
    if (mem_i.valid) begin
      repeat (dly_i) @(posedge clk_i);
      rvalid_o <= 1'b1;
      rdata_o <= held;
      @(posedge clk_i);
      rvalid_o <= 1'b0;
      rdata_o <= ~held;
    end
  end
endmodule
